// ===== logic/fsled_defs.svh
// Timing constants and encodings for the fieldbus status lamp driver.
// Assumes a 20 MHz system clock; included by bare name.
`ifndef FSLED_DEFS_SVH
`define FSLED_DEFS_SVH

`define FSLED_CLK_HZ        20000000
`define FSLED_BLINK_MS      200
`define FSLED_FLASH_OFF_MS  1000
`define FSLED_FLICKER_MS    50
`define FSLED_LDR_SLOW_HZ   1
`define FSLED_LDR_FAST_HZ   6
`define FSLED_MS_CYC        (`FSLED_CLK_HZ / 1000)
`define FSLED_FLICKER_CYC   (`FSLED_FLICKER_MS * `FSLED_MS_CYC)
`define FSLED_SLOW_HALF_CYC (`FSLED_CLK_HZ / (2 * `FSLED_LDR_SLOW_HZ))
`define FSLED_FAST_HALF_CYC (`FSLED_CLK_HZ / (2 * `FSLED_LDR_FAST_HZ))
`define FSLED_CHANGE_AUTO   8'h01
`define FSLED_DIAG_OBJ      16'h4000

`endif

// ===== logic/fsled_pkg.sv
// Types shared by the status lamp driver.
// No surroundings assumed.
package fsled_pkg;
	typedef enum logic [1:0] {
		FSLED_NET_INIT,
		FSLED_NET_PREOP,
		FSLED_NET_SAFEOP,
		FSLED_NET_OP
	} fsled_net_t;

	typedef enum logic [1:0] {
		FSLED_LDR_OFF,
		FSLED_LDR_IDLE,
		FSLED_LDR_BUSY,
		FSLED_LDR_RSVD
	} fsled_ldr_t;
endpackage

// ===== logic/fsled_half_timer.sv
// Free-running square wave whose half period is a count of clock cycles.
// Assumes a synchronous active-high reset.
`timescale 1ns/1ps
module fsled_half_timer #(
	parameter int HALF = 4
) (
	input  wire logic clk_sys,  // System clock.
	input  wire logic sys_rst,  // Synchronous reset.
	output logic      wave      // Square wave output.
);
	logic [23:0] cnt_q;
	logic        wave_q;
	wire         wrap = (cnt_q == 24'(HALF - 1));

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_q  <= 24'h000000;
			wave_q <= 1'b0;
		end else begin
			cnt_q  <= wrap ? 24'h000000 : cnt_q + 24'h000001;
			wave_q <= wrap ? ~wave_q : wave_q;
		end
	end

	assign wave = wave_q;
endmodule

// ===== logic/fsled_driver.sv
// Status lamp driver: two link/activity lamps, a green/red run lamp and a red error lamp.
// Inputs are synchronous to clk_sys; lamps are active high.
//
// Notes on behaviour
// - Drive four separate status lamps.
// - Link lamp dark without link or controller.
// - Link lamp steady green when linked, idle.
// - Link lamp flickers green with traffic.
// - Run lamp dark in Init.
// - Run lamp blinks green in Pre-Operational.
// - Run lamp single-flashes green in Safe-Operational.
// - Run lamp steady green in Operational.
// - Run lamp red only for loader, 1/6 Hz.
// - Error lamp blinks 1/6 Hz during loader.
// - Error lamp dark clean, blinks on config error.
// - Error single flash when change code 01.
// - Error double flash after watchdog timeout.
// - Error steady on interface or fatal fault.
// - Termination applied automatically when last node.
`timescale 1ns/1ps
`include "fsled_defs.svh"
module fsled_driver
	import fsled_pkg::*;
#(
	parameter int MS_CYC = `FSLED_MS_CYC
) (
	input  wire logic       clk_sys,      // System clock, 20 MHz.
	input  wire logic       sys_rst,      // Synchronous reset, active high.
	input  wire logic       ctrlStarted,  // Controller has started up.
	input  wire logic [1:0] portLink,     // Physical link per port.
	input  wire logic [1:0] portActive,   // Frames passing per port.
	input  wire fsled_net_t netState,     // Network state machine state.
	input  wire fsled_ldr_t loaderState,  // Firmware update loader activity.
	input  wire logic       cfgError,     // General configuration error.
	input  wire logic [7:0] changeCode,   // Status change indication.
	input  wire logic       wdogTimeout,  // Sync manager watchdog timeout seen.
	input  wire logic       pdiFail,      // Process data interface failure.
	input  wire logic       fatalStall,   // Fatal stall event.
	input  wire logic [7:0] stallCause,   // Cause code of the stall.
	input  wire logic       lastNode,     // No downstream neighbour present.
	output logic [1:0]      linkLampGrn,  // Link/activity lamps, green.
	output logic            runLampGrn,   // Run lamp, green.
	output logic            runLampRed,   // Run lamp, red.
	output logic            errLampRed,   // Error lamp, red.
	output logic            termEnable,   // Network termination applied.
	output logic [15:0]     diagObject,   // Diagnostic object index.
	output logic [7:0]      diagCause     // Latched stall cause.
);
	////////////////////////////////////////////////////////////////////////////
	// Pattern sequencer: one 50 ms tick, a 200 ms phase counter over 1400 ms.
	localparam int TICK_CYC   = `FSLED_FLICKER_MS * MS_CYC;
	localparam int PHASE_TICK = `FSLED_BLINK_MS / `FSLED_FLICKER_MS;
	localparam int FRAME_PH   = 2 + `FSLED_FLASH_OFF_MS / `FSLED_BLINK_MS;

	logic [23:0] tickCnt_q;
	logic [2:0]  subCnt_q;
	logic [2:0]  phase_q;
	logic        flick_q;

	wire tick     = (tickCnt_q == 24'(TICK_CYC - 1));
	wire phaseEnd = tick && (subCnt_q == 3'(PHASE_TICK - 1));

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tickCnt_q <= 24'h000000;
			subCnt_q  <= 3'h0;
			phase_q   <= 3'h0;
			flick_q   <= 1'b0;
		end else begin
			tickCnt_q <= tick ? 24'h000000 : tickCnt_q + 24'h000001;
			if (tick) begin
				flick_q  <= ~flick_q;
				subCnt_q <= phaseEnd ? 3'h0 : subCnt_q + 3'h1;
			end
			if (phaseEnd) begin
				phase_q <= (phase_q == 3'(FRAME_PH - 1)) ? 3'h0 : phase_q + 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Blink runs on its own 200 ms toggle, so a frame wrap never stretches an on phase.
	logic blink_q;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			blink_q <= 1'b1;
		end else if (phaseEnd) begin
			blink_q <= ~blink_q;
		end
	end

	// Flashes start a 1400 ms frame: one 200 ms pulse then 1200 ms dark, or two 200 ms pulses 200 ms apart then 800 ms dark.
	wire blinkWave  = blink_q;
	wire singleWave = (phase_q == 3'h0);
	wire doubleWave = (phase_q == 3'h0) || (phase_q == 3'h2);

	////////////////////////////////////////////////////////////////////////////
	// Loader blink rates.
	logic slowWave;
	logic fastWave;

	// Half periods are worked out from milliseconds so that they follow the MS_CYC parameter.
	fsled_half_timer #(.HALF((1000 * MS_CYC) / (2 * `FSLED_LDR_SLOW_HZ))) uSlow (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.wave    (slowWave)
	);

	fsled_half_timer #(.HALF((1000 * MS_CYC) / (2 * `FSLED_LDR_FAST_HZ))) uFast (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.wave    (fastWave)
	);

	wire loaderOn   = (loaderState == FSLED_LDR_IDLE) || (loaderState == FSLED_LDR_BUSY);
	wire loaderWave = (loaderState == FSLED_LDR_BUSY) ? fastWave : slowWave;

	////////////////////////////////////////////////////////////////////////////
	// Lamp selection.
	logic [1:0] linkSel;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : gLink
			assign linkSel[gi] = (ctrlStarted && portLink[gi])
				? (portActive[gi] ? flick_q : 1'b1) : 1'b0;
		end
	endgenerate

	logic runGrnSel;
	always_comb begin
		runGrnSel = 1'b0;
		unique case (netState)
			FSLED_NET_INIT:   runGrnSel = 1'b0;
			FSLED_NET_PREOP:  runGrnSel = blinkWave;
			FSLED_NET_SAFEOP: runGrnSel = singleWave;
			FSLED_NET_OP:     runGrnSel = 1'b1;
		endcase
	end

	wire runGrnD = loaderOn ? 1'b0 : runGrnSel;
	wire runRedD = loaderOn && loaderWave;

	// Error causes, highest priority first: loader, steady fault, watchdog, own change, configuration.
	wire errSteady = pdiFail || fatalStall;
	wire errDouble = wdogTimeout;
	wire errSingle = (changeCode == `FSLED_CHANGE_AUTO);
	wire errBlink  = cfgError;

	wire errD = loaderOn ? loaderWave :
		errSteady        ? 1'b1 :
		errDouble        ? doubleWave :
		errSingle        ? singleWave :
		errBlink         ? blinkWave : 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// Output registers.
	logic [1:0]  link_q;
	logic        runGrn_q;
	logic        runRed_q;
	logic        err_q;
	logic        term_q;
	logic [7:0]  cause_q;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			link_q   <= 2'h0;
			runGrn_q <= 1'b0;
			runRed_q <= 1'b0;
			err_q    <= 1'b0;
			term_q   <= 1'b0;
			cause_q  <= 8'h00;
		end else begin
			link_q   <= linkSel;
			runGrn_q <= runGrnD;
			runRed_q <= runRedD;
			err_q    <= errD;
			term_q   <= lastNode;
			if (fatalStall) begin
				cause_q <= stallCause;
			end
		end
	end

	assign linkLampGrn = link_q;
	assign runLampGrn  = runGrn_q;
	assign runLampRed  = runRed_q;
	assign errLampRed  = err_q;
	assign termEnable  = term_q;
	assign diagObject  = `FSLED_DIAG_OBJ;
	assign diagCause   = cause_q;

	////////////////////////////////////////////////////////////////////////////
	// Watch of the blink on-time: counts cycles the run lamp stands lit while blinking.
	localparam int BLINK_CYC = PHASE_TICK * TICK_CYC;

	logic [23:0] grnLit_q;
	wire         grnBlinking = runLampGrn && (netState == FSLED_NET_PREOP) && !loaderOn;

	always_ff @(posedge clk_sys) begin
		if (sys_rst || !grnBlinking) begin
			grnLit_q <= 24'h000000;
		end else begin
			grnLit_q <= grnLit_q + 24'h000001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	for (genvar pi = 0; pi < 2; pi++) begin : gLinkChk
		a_link_nolink: assert property (@(posedge clk_sys) disable iff (sys_rst)
			!portLink[pi] |=> !linkLampGrn[pi]) else $error("link lamp lit without link");
		a_link_flicker: assert property (@(posedge clk_sys) disable iff (sys_rst)
			ctrlStarted && portLink[pi] && portActive[pi] |=> linkLampGrn[pi] == $past(flick_q))
			else $error("link lamp not flickering");
	end
	a_run_blink: assert property (@(posedge clk_sys) disable iff (sys_rst)
		grnLit_q <= 24'(BLINK_CYC + 1)) else $error("run blink on too long");
	a_run_safeop: assert property (@(posedge clk_sys) disable iff (sys_rst)
		netState == FSLED_NET_SAFEOP && !loaderOn |=> runLampGrn == $past(singleWave))
		else $error("run lamp not single flashing");
	a_err_loader: assert property (@(posedge clk_sys) disable iff (sys_rst)
		loaderOn |=> errLampRed == $past(loaderWave)) else $error("error lamp not loader blink");
	a_err_double: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!loaderOn && !errSteady && errDouble |=> errLampRed == $past(doubleWave))
		else $error("error lamp not double flashing");
	a_err_single: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!loaderOn && !errSteady && !errDouble && errSingle |=> errLampRed == $past(singleWave))
		else $error("error lamp not single flashing");
	a_err_blink: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!loaderOn && !errSteady && !errDouble && !errSingle && errBlink |=> errLampRed == $past(blinkWave))
		else $error("error lamp not blinking");
	a_cause_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!fatalStall |=> $stable(diagCause)) else $error("stall cause changed without stall");
	a_link_dark: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!ctrlStarted |=> linkLampGrn == 2'h0) else $error("link lamp lit without controller");
	a_link_steady: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ctrlStarted && portLink[0] && !portActive[0] |=> linkLampGrn[0]) else $error("link lamp not steady");
	a_run_init: assert property (@(posedge clk_sys) disable iff (sys_rst)
		netState == FSLED_NET_INIT |=> !runLampGrn) else $error("run lamp lit in init");
	a_run_op: assert property (@(posedge clk_sys) disable iff (sys_rst)
		netState == FSLED_NET_OP && !loaderOn |=> runLampGrn) else $error("run lamp dark in operational");
	a_run_red_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!loaderOn |=> !runLampRed) else $error("run red without loader");
	a_lamp_exclusive: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!(runLampRed && runLampGrn)) else $error("run lamp both colours");
	a_err_fatal: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!loaderOn && fatalStall |=> errLampRed) else $error("error lamp dark on fatal");
	a_err_clean: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!loaderOn && !pdiFail && !fatalStall && !wdogTimeout && !cfgError
		&& changeCode != `FSLED_CHANGE_AUTO |=> !errLampRed) else $error("error lamp lit clean");
	a_term_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
		lastNode |=> termEnable) else $error("termination not applied");
	a_phase_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
		phase_q < 3'(FRAME_PH)) else $error("phase out of range");

	c_flicker: cover property (@(posedge clk_sys) disable iff (sys_rst) linkLampGrn[0] ##1 !linkLampGrn[0]);
	c_loader: cover property (@(posedge clk_sys) disable iff (sys_rst) runLampRed);
	c_double: cover property (@(posedge clk_sys) disable iff (sys_rst) wdogTimeout && phase_q == 3'h2);
	c_single: cover property (@(posedge clk_sys) disable iff (sys_rst) errSingle && !errDouble && errLampRed);
	c_preop_blink: cover property (@(posedge clk_sys) disable iff (sys_rst) grnBlinking ##1 !runLampGrn);
endmodule

// ===== tb/fsled_panel.sv
// Front-panel lamp watcher: counts lit cycles and light-ups of one lamp.
// Assumes the lamp is sampled on clk_sys; clr starts a fresh count window.
`timescale 1ns/1ps
module fsled_panel (
	input  wire logic   clk_sys,  // System clock.
	input  wire logic   clr,      // Restart the counts.
	input  wire logic   lamp,     // Lamp drive, lit high.
	output logic [31:0] onCycles, // Cycles seen lit.
	output logic [31:0] lightUps  // Dark to lit changes.
);
	logic lit_q;
	// An unknown lamp level poisons the counts, so it cannot pass for dark.
	always_ff @(posedge clk_sys) begin
		lit_q <= lamp;
		if (clr) begin
			onCycles <= 32'h0;
			lightUps <= 32'h0;
		end else begin
			onCycles <= onCycles + {31'h0, lamp};
			lightUps <= lightUps + {31'h0, lamp & ~lit_q};
		end
	end
endmodule

// ===== tb/fieldbus_status_led_driver_bench.sv
// Self-checking bench for the status lamp driver.
// Assumes fsled_pkg and fsled_panel are compiled first; lamp timers scaled to 2 cycles per ms.
`timescale 1ns/1ps
module fieldbus_status_led_driver_bench;
	import fsled_pkg::*;
	localparam int MS = 2;
	logic       clk_sys = 1'b0;
	logic       sys_rst = 1'b1;
	logic       ctrlStarted = 1'b1, cfgError = 1'b0, wdogTimeout = 1'b0, pdiFail = 1'b1;
	logic       fatalStall = 1'b0, lastNode = 1'b0, clr = 1'b0;
	logic [1:0] portLink = 2'h3, portActive = 2'h0, linkLampGrn;
	fsled_net_t netState = FSLED_NET_OP;
	fsled_ldr_t loaderState = FSLED_LDR_OFF;
	logic [7:0] changeCode = 8'h00, stallCause = 8'h00, diagCause;
	logic       runLampGrn, runLampRed, errLampRed, termEnable;
	logic [15:0] diagObject;
	logic [4:0] lamps;
	logic [31:0] onC [5];
	logic [31:0] ups [5];
	int         bad_count = 0;
	int         checks_done = 0;
	assign lamps = {errLampRed, runLampRed, runLampGrn, linkLampGrn};
	fsled_driver #(.MS_CYC(MS)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .ctrlStarted(ctrlStarted),
		.portLink(portLink), .portActive(portActive), .netState(netState), .loaderState(loaderState),
		.cfgError(cfgError), .changeCode(changeCode), .wdogTimeout(wdogTimeout), .pdiFail(pdiFail),
		.fatalStall(fatalStall), .stallCause(stallCause), .lastNode(lastNode), .linkLampGrn(linkLampGrn),
		.runLampGrn(runLampGrn), .runLampRed(runLampRed), .errLampRed(errLampRed), .termEnable(termEnable),
		.diagObject(diagObject), .diagCause(diagCause));
	for (genvar i = 0; i < 5; i++) begin : g_lamp
		fsled_panel panel (.clk_sys(clk_sys), .clr(clr), .lamp(lamps[i]), .onCycles(onC[i]), .lightUps(ups[i]));
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#5;
	endtask
	// Lets the lamps settle, then counts over the requested number of milliseconds.
	task automatic measure(input int ms);
		tick(20);
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		tick(ms * MS);
	endtask
	task automatic final_report();
		if (bad_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic reset_hold();
		tick(20);
		check({27'h0, lamps}, 32'h0);
		check({24'h0, diagCause}, 32'h0);
		sys_rst = 1'b0;
		pdiFail = 1'b0;
		netState = FSLED_NET_INIT;
	endtask
	task automatic link_lamps();
		ctrlStarted = 1'b0;
		measure(1400);
		check(onC[0] | onC[1], 32'h0);
		ctrlStarted = 1'b1;
		portLink = 2'h1;
		measure(1400);
		check(onC[0], 1400 * MS);
		check(onC[1], 32'h0);
		portLink = 2'h3;
		portActive = 2'h2;
		measure(1400);
		check(onC[0], 1400 * MS);
		check(ups[1], 32'h0E);
		check(onC[1], 700 * MS);
	endtask
	task automatic run_states();
		int onMs [4] = '{0, 1400, 400, 2800};
		int upN [4] = '{0, 7, 2, 0};
		for (int s = 0; s < 4; s++) begin
			netState = fsled_net_t'(s);
			measure(2800);
			check(onC[2], onMs[s] * MS);
			check(ups[2], upN[s]);
			check(onC[3], 32'h0);
		end
	endtask
	task automatic err_states();
		logic [4:0] mode [7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h08, 5'h10};
		int onMs [7] = '{0, 1400, 400, 800, 800, 2800, 2800};
		int upN [7] = '{0, 7, 2, 4, 4, 0, 0};
		stallCause = 8'hA5;
		for (int m = 0; m < 7; m++) begin
			cfgError = mode[m][0];
			changeCode = mode[m][1] ? 8'h01 : 8'h02;
			wdogTimeout = mode[m][2];
			pdiFail = mode[m][3];
			fatalStall = mode[m][4];
			measure(2800);
			check(onC[4], onMs[m] * MS);
			check(ups[4], upN[m]);
		end
		fatalStall = 1'b0;
		stallCause = 8'h3C;
		tick(3);
		check({24'h0, diagCause}, 32'hA5);
		check({16'h0, diagObject}, 32'h4000);
	endtask
	task automatic loader_rates();
		loaderState = FSLED_LDR_IDLE;
		measure(3000);
		check(ups[3], 32'h3);
		check(ups[4], 32'h3);
		check(onC[2], 32'h0);
		loaderState = FSLED_LDR_BUSY;
		measure(3000);
		check({31'h0, ups[3] >= 17 && ups[3] <= 19}, 32'h1);
		check({31'h0, ups[4] >= 17 && ups[4] <= 19}, 32'h1);
		loaderState = FSLED_LDR_OFF;
		measure(1400);
		check(onC[3], 32'h0);
	endtask
	task automatic termination();
		lastNode = 1'b1;
		tick(2);
		check({31'h0, termEnable}, 32'h1);
		lastNode = 1'b0;
		tick(2);
		check({31'h0, termEnable}, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		reset_hold();
		link_lamps();
		run_states();
		err_states();
		loader_rates();
		termination();
		final_report();
	end
endmodule
